// [pcsf_cycle_status.sv]
// status flags for channel six and seven pwm cycle compare and channel six count direction
`timescale 1ns/100ps
`include "pcsf_map.svh"
module pcsf_cycle_status
	import pcsf_pkg::*;
(
	input  wire logic       core_clk,       // timer clock, 10 MHz
	input  wire logic       arst_n,         // asynchronous reset, active low
	input  wire pcsf_addr_t reg_addr,       // register index
	input  wire pcsf_word_t reg_wdata,      // write data
	input  wire logic       reg_wr,         // write strobe
	input  wire logic       reg_rd,         // read strobe
	output pcsf_word_t      reg_rdata,      // read data, cycle after strobe
	input  wire logic       comp_pwm_mode,  // complementary pwm operation
	input  wire pcsf_sub_t  dir_down_six,   // ch6 counter d..a counting down
	input  wire pcsf_word_t cnt_six_a,      // ch6 counter a
	input  wire pcsf_word_t cnt_six_b,      // ch6 counter b
	input  wire pcsf_word_t cnt_six_c,      // ch6 counter c
	input  wire pcsf_word_t cnt_six_d,      // ch6 counter d
	input  wire pcsf_word_t cyc_six_a,      // ch6 cycle register a
	input  wire pcsf_word_t cyc_six_b,      // ch6 cycle register b
	input  wire pcsf_word_t cyc_six_c,      // ch6 cycle register c
	input  wire pcsf_word_t cyc_six_d,      // ch6 cycle register d
	input  wire pcsf_word_t cnt_seven_a,    // ch7 counter a
	input  wire pcsf_word_t cnt_seven_b,    // ch7 counter b
	input  wire pcsf_word_t cnt_seven_c,    // ch7 counter c
	input  wire pcsf_word_t cnt_seven_d,    // ch7 counter d
	input  wire pcsf_word_t cyc_seven_a,    // ch7 cycle register a
	input  wire pcsf_word_t cyc_seven_b,    // ch7 cycle register b
	input  wire pcsf_word_t cyc_seven_c,    // ch7 cycle register c
	input  wire pcsf_word_t cyc_seven_d,    // ch7 cycle register d
	output logic            irq             // level interrupt
);
	// ----------------------------------------------------------------
	// match detection
	// ----------------------------------------------------------------
	function automatic pcsf_sub_t eq4(input pcsf_word_t c0, input pcsf_word_t c1,
		input pcsf_word_t c2, input pcsf_word_t c3, input pcsf_word_t r0,
		input pcsf_word_t r1, input pcsf_word_t r2, input pcsf_word_t r3);
		eq4 = {c3 == r3, c2 == r2, c1 == r1, c0 == r0};
	endfunction : eq4

	pcsf_sub_t  dir_q;
	pcsf_sub_t  prev_six;
	pcsf_sub_t  prev_seven;
	pcsf_sub_t  hit_six;
	pcsf_sub_t  hit_seven;
	pcsf_sub_t  zero_six;
	pcsf_sub_t  set_six;
	pcsf_sub_t  set_seven;
	pcsf_sub_t  flags_six;
	pcsf_sub_t  flags_seven;
	logic [7:0] irq_status;
	logic [7:0] irq_mask;
	logic [7:0] next_irq_status;
	logic [7:0] next_irq_mask;
	pcsf_word_t next_rdata;
	pcsf_sub_t  next_dir;
	pcsf_sub_t  next_prev_six;
	pcsf_sub_t  next_prev_seven;

	assign hit_six   = eq4(cnt_six_a, cnt_six_b, cnt_six_c, cnt_six_d,
		cyc_six_a, cyc_six_b, cyc_six_c, cyc_six_d);
	assign hit_seven = eq4(cnt_seven_a, cnt_seven_b, cnt_seven_c, cnt_seven_d,
		cyc_seven_a, cyc_seven_b, cyc_seven_c, cyc_seven_d);
	assign zero_six  = eq4(cnt_six_a, cnt_six_b, cnt_six_c, cnt_six_d,
		16'h0000, 16'h0000, 16'h0000, 16'h0000) & dir_down_six;

	// a counter may sit on its match for many ticks; only the first cycle sets
	always_comb begin
		pcsf_sub_t cond_six;
		pcsf_sub_t cond_seven;
		cond_six        = comp_pwm_mode ? zero_six : hit_six;
		cond_seven      = comp_pwm_mode ? 4'h0 : hit_seven;
		set_six         = cond_six & ~prev_six;
		set_seven       = cond_seven & ~prev_seven;
		next_prev_six   = cond_six;
		next_prev_seven = cond_seven;
		next_dir        = dir_down_six;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			prev_six   <= 4'h0;
			prev_seven <= 4'h0;
			dir_q      <= `PCSF_RST_FLAGS;
		end else begin
			prev_six   <= next_prev_six;
			prev_seven <= next_prev_seven;
			dir_q      <= next_dir;
		end
	end

	// ----------------------------------------------------------------
	// flag banks
	// ----------------------------------------------------------------
	pcsf_flag_bank u_bank_six (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.set_evt  (set_six),
		.rd_hit   (reg_rd && reg_addr == `PCSF_OFF_STATUS_SIX),
		.wr_hit   (reg_wr && reg_addr == `PCSF_OFF_STATUS_SIX),
		.wr_flags (reg_wdata[`PCSF_FLAG_MSB:`PCSF_FLAG_LSB]),
		.flags    (flags_six)
	);

	pcsf_flag_bank u_bank_seven (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.set_evt  (set_seven),
		.rd_hit   (reg_rd && reg_addr == `PCSF_OFF_STATUS_SEVEN),
		.wr_hit   (reg_wr && reg_addr == `PCSF_OFF_STATUS_SEVEN),
		.wr_flags (reg_wdata[`PCSF_FLAG_MSB:`PCSF_FLAG_LSB]),
		.flags    (flags_seven)
	);

	// ----------------------------------------------------------------
	// interrupt status and mask
	// ----------------------------------------------------------------
	// a set beats a write-one-clear in the same cycle, as in the flag banks
	always_comb begin
		next_irq_status = irq_status;
		next_irq_mask   = irq_mask;
		if (reg_wr && reg_addr == `PCSF_OFF_IRQ_STATUS) begin
			next_irq_status = irq_status & ~reg_wdata[7:0];
		end
		if (reg_wr && reg_addr == `PCSF_OFF_IRQ_MASK) begin
			next_irq_mask = reg_wdata[7:0];
		end
		next_irq_status = next_irq_status | {set_seven, set_six};
	end

	// irq is built from the next values so it moves in step with the status bits
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_status <= `PCSF_RST_IRQ;
			irq_mask   <= `PCSF_RST_IRQ;
			irq        <= 1'b0;
		end else begin
			irq_status <= next_irq_status;
			irq_mask   <= next_irq_mask;
			irq        <= |(next_irq_status & next_irq_mask);
		end
	end

	// ----------------------------------------------------------------
	// register read
	// ----------------------------------------------------------------
	// both status words share one layout; channel seven passes a zero direction
	function automatic pcsf_word_t status_word(input pcsf_sub_t dir, input pcsf_sub_t flg);
		status_word = {8'h00, dir, flg};
	endfunction : status_word

	// read data fall to zero outside the answer cycle, so no stale word lingers
	always_comb begin
		next_rdata = 16'h0000;
		if (reg_rd) begin
			case (reg_addr)
				`PCSF_OFF_STATUS_SIX:   next_rdata = status_word(dir_q, flags_six);
				`PCSF_OFF_STATUS_SEVEN: next_rdata = status_word(4'h0, flags_seven);
				`PCSF_OFF_IRQ_STATUS:   next_rdata = {8'h00, irq_status};
				`PCSF_OFF_IRQ_MASK:     next_rdata = {8'h00, irq_mask};
				default:                next_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 16'h0000;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

	// ----------------------------------------------------------------
	// checks: register read
	// ----------------------------------------------------------------
	sequence rd_seven_s;
		reg_rd && reg_addr == `PCSF_OFF_STATUS_SEVEN;
	endsequence

	sequence rd_six_s;
		reg_rd && reg_addr == `PCSF_OFF_STATUS_SIX;
	endsequence

	sequence rd_unmapped_s;
		reg_rd && reg_addr > `PCSF_OFF_IRQ_MASK;
	endsequence

	reserved_zero_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		reg_rdata[15:8] == 8'h00)
		else $error("reserved byte not zero");
	seven_dir_zero_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		rd_seven_s |=> reg_rdata[7:4] == 4'h0)
		else $error("channel seven direction bits not zero");
	six_dir_shown_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		rd_six_s |=> reg_rdata[7:4] == $past(dir_q))
		else $error("direction bits wrong");
	six_flags_shown_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		rd_six_s |=> reg_rdata[3:0] == $past(flags_six))
		else $error("channel six flags read back wrong");
	seven_flags_shown_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		rd_seven_s |=> reg_rdata[3:0] == $past(flags_seven))
		else $error("channel seven flags read back wrong");
	idle_rdata_zero_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		!reg_rd |=> reg_rdata == 16'h0000)
		else $error("read data not zero outside the answer cycle");
	unmapped_zero_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		rd_unmapped_s |=> reg_rdata == 16'h0000)
		else $error("unmapped index did not read zero");

	// the first cycle out of reset is skipped: direction is still held at zero then
	dir_follows_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		arst_n |=> dir_q == $past(dir_down_six))
		else $error("direction bits do not follow the counters");

	// ----------------------------------------------------------------
	// checks: flag setting and clearing
	// ----------------------------------------------------------------
	sequence six_quiet_read_s;
		reg_rd && reg_addr == `PCSF_OFF_STATUS_SIX && set_six == 4'h0;
	endsequence

	sequence six_quiet_s;
		!(reg_wr && reg_addr == `PCSF_OFF_STATUS_SIX) && set_six == 4'h0;
	endsequence

	sequence six_clear_s;
		reg_wr && reg_addr == `PCSF_OFF_STATUS_SIX && reg_wdata[3:0] == 4'h0 && set_six == 4'h0;
	endsequence

	sequence seven_quiet_read_s;
		reg_rd && reg_addr == `PCSF_OFF_STATUS_SEVEN && set_seven == 4'h0;
	endsequence

	sequence seven_quiet_s;
		!(reg_wr && reg_addr == `PCSF_OFF_STATUS_SEVEN) && set_seven == 4'h0;
	endsequence

	sequence seven_clear_s;
		reg_wr && reg_addr == `PCSF_OFF_STATUS_SEVEN && reg_wdata[3:0] == 4'h0 && set_seven == 4'h0;
	endsequence

	six_match_sets_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(!comp_pwm_mode && (hit_six & ~prev_six) != 4'h0) |=>
		(($past(hit_six) & ~$past(prev_six) & ~flags_six) == 4'h0))
		else $error("channel six match did not set flag");
	match_sets_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(!comp_pwm_mode && (hit_seven & ~prev_seven) != 4'h0) |=>
		(($past(hit_seven) & ~$past(prev_seven) & ~flags_seven) == 4'h0))
		else $error("match did not set flag");
	zero_down_sets_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(comp_pwm_mode && (zero_six & ~prev_six) != 4'h0) |=>
		(($past(zero_six) & ~$past(prev_six) & ~flags_six) == 4'h0))
		else $error("zero in down count did not set flag");
	comp_no_seven_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		comp_pwm_mode |=> (flags_seven & ~$past(flags_seven)) == 4'h0)
		else $error("channel seven set in complementary mode");

	// a zero write two cycles after an undisturbed read must clear everything it saw
	six_read_clear_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		six_quiet_read_s ##1 six_quiet_s ##1 six_clear_s |=> flags_six == 4'h0)
		else $error("read then write zero left a channel six flag set");
	seven_read_clear_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		seven_quiet_read_s ##1 seven_quiet_s ##1 seven_clear_s |=> flags_seven == 4'h0)
		else $error("read then write zero left a channel seven flag set");

	// ----------------------------------------------------------------
	// checks: interrupt
	// ----------------------------------------------------------------
	sequence irq_clear_s;
		reg_wr && reg_addr == `PCSF_OFF_IRQ_STATUS;
	endsequence

	sequence mask_write_s;
		reg_wr && reg_addr == `PCSF_OFF_IRQ_MASK;
	endsequence

	irq_level_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(irq_status & irq_mask) != 8'h00 |-> irq)
		else $error("interrupt not raised");
	irq_low_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(irq_status & irq_mask) == 8'h00 |-> !irq)
		else $error("interrupt raised with nothing pending");
	event_to_status_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		({set_seven, set_six} != 8'h00) |=>
		(({$past(set_seven), $past(set_six)} & ~irq_status) == 8'h00))
		else $error("event did not reach the interrupt status");
	irq_wr_clear_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		irq_clear_s |=>
		(({8'h00, irq_status} & $past(reg_wdata) & ~{8'h00, $past(set_seven), $past(set_six)})
		== 16'h0000))
		else $error("write one did not clear interrupt status");
	irq_sticky_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		!(reg_wr && reg_addr == `PCSF_OFF_IRQ_STATUS) |=>
		((irq_status & $past(irq_status)) == $past(irq_status)))
		else $error("interrupt status bit lost without a clear");
	mask_lands_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		mask_write_s |=> {8'h00, irq_mask} == ($past(reg_wdata) & 16'h00FF))
		else $error("mask write did not land");
endmodule : pcsf_cycle_status

// [pcsf_map.svh]
// register offsets, field positions and reset values for the cycle status flags
`ifndef PCSF_MAP_SVH
`define PCSF_MAP_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PCSF_OFF_STATUS_SIX   4'h0
`define PCSF_OFF_STATUS_SEVEN 4'h1
`define PCSF_OFF_IRQ_STATUS   4'h2
`define PCSF_OFF_IRQ_MASK     4'h3

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define PCSF_FLAG_LSB   0
`define PCSF_FLAG_MSB   3
`define PCSF_DIR_LSB    4
`define PCSF_DIR_MSB    7
`define PCSF_RSV_LSB    8
`define PCSF_RSV_MSB    15
`define PCSF_RST_FLAGS  4'h0
`define PCSF_RST_IRQ    8'h00

`endif

// [pcsf_pkg.sv]
// types shared by the cycle status flag block
package pcsf_pkg;
	typedef logic [15:0] pcsf_word_t;
	typedef logic [3:0]  pcsf_sub_t;
	typedef logic [3:0]  pcsf_addr_t;
endpackage : pcsf_pkg

// [pcsf_flag_bank.sv]
// one channel's four sticky cycle match flags with read-then-write-zero clearing
`timescale 1ns/100ps
`include "pcsf_map.svh"
module pcsf_flag_bank
	import pcsf_pkg::*;
(
	input  wire logic      core_clk,   // timer clock
	input  wire logic      arst_n,     // asynchronous reset
	input  wire pcsf_sub_t set_evt,    // per-subchannel set event
	input  wire logic      rd_hit,     // this register is being read
	input  wire logic      wr_hit,     // this register is being written
	input  wire pcsf_sub_t wr_flags,   // written value of bits 3..0
	output pcsf_sub_t      flags       // sticky flags
);
	pcsf_sub_t armed;
	pcsf_sub_t next_flags;
	pcsf_sub_t next_armed;

	// ----------------------------------------------------------------
	// flags and read-armed bits
	// ----------------------------------------------------------------
	always_comb begin
		pcsf_sub_t clr;
		clr        = wr_hit ? (armed & ~wr_flags) : 4'h0;
		next_flags = (flags & ~clr) | set_evt;
		// a read arms only the bits it saw set; a write disarms unless a read comes in the same cycle
		next_armed = armed;
		if (wr_hit) begin
			next_armed = 4'h0;
		end
		if (rd_hit) begin
			next_armed = flags;
		end
		next_armed = next_armed & next_flags;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			flags <= `PCSF_RST_FLAGS;
			armed <= `PCSF_RST_FLAGS;
		end else begin
			flags <= next_flags;
			armed <= next_armed;
		end
	end

	clear_needs_read_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(flags != 4'h0 && armed == 4'h0 && !rd_hit) |=> ((flags & $past(flags)) == $past(flags)))
		else $error("flag cleared without prior read");
	set_wins_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(set_evt != 4'h0) |=> ((flags & $past(set_evt)) == $past(set_evt)))
		else $error("set event lost");
	write_one_keeps_a: assert property (@(posedge core_clk) disable iff (!arst_n)
		(wr_hit && wr_flags == 4'hF) |=> ((flags & $past(flags)) == $past(flags)))
		else $error("writing ones cleared a flag");
endmodule : pcsf_flag_bank

// [tb.sv]
// self-checking testbench for the cycle status flag block
`timescale 1ns/100ps
`include "pcsf_map.svh"
module tb
	import pcsf_pkg::*;
;
	logic       core_clk      = 1'b0;
	logic       arst_n        = 1'b0;
	pcsf_addr_t reg_addr      = 4'h0;
	pcsf_word_t reg_wdata     = 16'h0000;
	logic       reg_wr        = 1'b0;
	logic       reg_rd        = 1'b0;
	logic       comp_pwm_mode = 1'b0;
	pcsf_sub_t  dir_down_six  = 4'h0;
	pcsf_word_t reg_rdata;
	logic       irq;
	pcsf_word_t cs [4]        = '{default: 16'h0100};
	pcsf_word_t ys [4]        = '{default: 16'h0200};
	pcsf_word_t c7 [4]        = '{default: 16'h0100};
	pcsf_word_t y7 [4]        = '{default: 16'h0300};
	int         fails         = 0;
	int         comparisons   = 0;

	always #50 core_clk = ~core_clk;

	pcsf_cycle_status i_pcsf_cycle_status (.core_clk(core_clk), .arst_n(arst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .comp_pwm_mode(comp_pwm_mode), .dir_down_six(dir_down_six),
		.cnt_six_a(cs[0]), .cnt_six_b(cs[1]), .cnt_six_c(cs[2]), .cnt_six_d(cs[3]),
		.cyc_six_a(ys[0]), .cyc_six_b(ys[1]), .cyc_six_c(ys[2]), .cyc_six_d(ys[3]),
		.cnt_seven_a(c7[0]), .cnt_seven_b(c7[1]), .cnt_seven_c(c7[2]), .cnt_seven_d(c7[3]),
		.cyc_seven_a(y7[0]), .cyc_seven_b(y7[1]), .cyc_seven_c(y7[2]), .cyc_seven_d(y7[3]),
		.irq(irq));

	// --------------------
	// bus and event tasks
	// --------------------
	task chk(input pcsf_word_t got, input pcsf_word_t exp);
		comparisons++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task wr(input pcsf_addr_t a, input pcsf_word_t d);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// read data stands only in the cycle after the strobe edge
	task rd(input pcsf_addr_t a, input pcsf_word_t e);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, e);
	endtask : rd

	// one-cycle match; flags set on the first matching cycle only
	task hit(input int ch, input int i);
		@(posedge core_clk);
		if (ch == 6) cs[i] <= ys[i];
		else c7[i] <= y7[i];
		@(posedge core_clk);
		cs[i] <= 16'h0100;
		c7[i] <= 16'h0100;
		repeat (2) @(posedge core_clk);
	endtask : hit

	task irq_is(input logic e);
		repeat (2) @(posedge core_clk);
		#1;
		chk({15'h0000, irq}, {15'h0000, e});
	endtask : irq_is

	task end_of_test;
		$display("comparisons %0d, mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : end_of_test

	// --------------------
	// tests
	// --------------------
	task t_reset;
		rd(`PCSF_OFF_STATUS_SIX, 16'h0000);
		rd(`PCSF_OFF_STATUS_SEVEN, 16'h0000);
		rd(4'h7, 16'h0000);
		$display("test reset done");
	endtask : t_reset

	task t_dir;
		@(posedge core_clk);
		dir_down_six <= 4'hA;
		repeat (2) @(posedge core_clk);
		rd(`PCSF_OFF_STATUS_SIX, 16'h00A0);
		rd(`PCSF_OFF_STATUS_SEVEN, 16'h0000);
		@(posedge core_clk);
		dir_down_six <= 4'h0;
		$display("test direction done");
	endtask : t_dir

	task t_match_clear;
		wr(`PCSF_OFF_IRQ_MASK, 16'h00FF);
		hit(6, 1);
		hit(7, 3);
		rd(`PCSF_OFF_STATUS_SIX, 16'h0002);
		rd(`PCSF_OFF_STATUS_SEVEN, 16'h0008);
		rd(`PCSF_OFF_IRQ_STATUS, 16'h0082);
		irq_is(1'b1);
		wr(`PCSF_OFF_STATUS_SEVEN, 16'h0008);
		wr(`PCSF_OFF_STATUS_SEVEN, 16'h0000);
		rd(`PCSF_OFF_STATUS_SEVEN, 16'h0008);
		wr(`PCSF_OFF_STATUS_SEVEN, 16'h0000);
		rd(`PCSF_OFF_STATUS_SEVEN, 16'h0000);
		wr(`PCSF_OFF_STATUS_SIX, 16'h0000);
		rd(`PCSF_OFF_STATUS_SIX, 16'h0000);
		wr(`PCSF_OFF_IRQ_STATUS, 16'h0082);
		irq_is(1'b0);
		$display("test match and clear done");
	endtask : t_match_clear

	task t_race;
		hit(6, 0);
		rd(`PCSF_OFF_STATUS_SIX, 16'h0001);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= `PCSF_OFF_STATUS_SIX;
		reg_wdata <= 16'h0000;
		cs[0]     <= ys[0];
		@(posedge core_clk);
		reg_wr <= 1'b0;
		cs[0]  <= 16'h0100;
		rd(`PCSF_OFF_STATUS_SIX, 16'h0001);
		wr(`PCSF_OFF_STATUS_SIX, 16'h0000);
		rd(`PCSF_OFF_STATUS_SIX, 16'h0000);
		$display("test set beats clear done");
	endtask : t_race

	// only a down-counting zero sets in complementary mode
	task t_comp;
		wr(`PCSF_OFF_IRQ_STATUS, 16'h00FF);
		wr(`PCSF_OFF_IRQ_MASK, 16'h0000);
		@(posedge core_clk);
		comp_pwm_mode <= 1'b1;
		dir_down_six  <= 4'h1;
		repeat (2) @(posedge core_clk);
		cs[0] <= 16'h0000;
		cs[2] <= 16'h0000;
		cs[3] <= ys[3];
		c7[1] <= y7[1];
		@(posedge core_clk);
		foreach (cs[i]) cs[i] <= 16'h0100;
		c7[1]         <= 16'h0100;
		comp_pwm_mode <= 1'b0;
		rd(`PCSF_OFF_STATUS_SIX, 16'h0011);
		rd(`PCSF_OFF_STATUS_SEVEN, 16'h0000);
		irq_is(1'b0);
		wr(`PCSF_OFF_IRQ_MASK, 16'h0001);
		irq_is(1'b1);
		$display("test complementary done");
	endtask : t_comp

	// a reset in mid-run must drop the flags set by the earlier tests
	task t_rerun;
		@(posedge core_clk);
		arst_n       <= 1'b0;
		dir_down_six <= 4'h0;
		repeat (2) @(posedge core_clk);
		arst_n <= 1'b1;
		rd(`PCSF_OFF_STATUS_SIX, 16'h0000);
		rd(`PCSF_OFF_STATUS_SEVEN, 16'h0000);
		rd(`PCSF_OFF_IRQ_STATUS, 16'h0000);
		irq_is(1'b0);
		$display("test mid-run reset done");
	endtask : t_rerun

	initial begin
		repeat (20) @(posedge core_clk);
		arst_n <= 1'b1;
		t_reset;
		t_dir;
		t_match_clear;
		t_race;
		t_comp;
		t_rerun;
		end_of_test;
	end

	// tests need about 115 cycles; allow 1000
	initial begin
		#100000;
		fails++;
		end_of_test;
	end
endmodule : tb
